// ==== common/dcbf_pkg.sv ====
// Shared constants and helper functions of the dual clock bidirectional buffer
package dcbf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 36;
  localparam int DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int PTR_W = 7;
  localparam int BYTE_W = 9;
  localparam int NUM_BYTES = 4;
  localparam logic [PTR_W-1:0] DEPTH_CNT = 7'h40;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam logic [PTR_W-1:0] PTR_RST = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0;
  localparam logic [1:0] AWAKE_RST = 2'h0;

  // ----------------------------------------------------------------
  // Preset flag offsets chosen by the two offset select inputs
  // ----------------------------------------------------------------
  localparam logic [PTR_W-1:0] OFFSET_SEL0 = 7'h10;
  localparam logic [PTR_W-1:0] OFFSET_SEL1 = 7'h0C;
  localparam logic [PTR_W-1:0] OFFSET_SEL2 = 7'h08;
  localparam logic [PTR_W-1:0] OFFSET_SEL3 = 7'h04;
  localparam logic [PTR_W-1:0] OFFSET_RST = 7'h10;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Binary to gray
  function automatic logic [PTR_W-1:0] dcbf_bin2gray(input logic [PTR_W-1:0] b);
    dcbf_bin2gray = b ^ (b >> 1);
  endfunction

  // Gray to binary
  function automatic logic [PTR_W-1:0] dcbf_gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = '0;
    b[PTR_W-1] = g[PTR_W-1];
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    dcbf_gray2bin = b;
  endfunction

  // True when every byte of a word has the selected parity
  function automatic logic dcbf_parity_ok(input logic [DATA_W-1:0] w, input logic odd);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < NUM_BYTES; i++) begin
      if ((^w[i*BYTE_W +: BYTE_W]) != odd) begin
        ok = 1'b0;
      end
    end
    dcbf_parity_ok = ok;
  endfunction

  // Replace the top bit of each byte with generated parity
  function automatic logic [DATA_W-1:0] dcbf_parity_gen(input logic [DATA_W-1:0] w, input logic odd);
    logic [DATA_W-1:0] r;
    r = w;
    for (int i = 0; i < NUM_BYTES; i++) begin
      r[i*BYTE_W + BYTE_W - 1] = (^w[i*BYTE_W +: BYTE_W-1]) ^ odd;
    end
    dcbf_parity_gen = r;
  endfunction

  // Offset select decode
  function automatic logic [PTR_W-1:0] dcbf_offset(input logic [1:0] sel);
    logic [PTR_W-1:0] o;
    o = OFFSET_SEL0;
    case (sel)
      2'h0: o = OFFSET_SEL0;
      2'h1: o = OFFSET_SEL1;
      2'h2: o = OFFSET_SEL2;
      default: o = OFFSET_SEL3;
    endcase
    dcbf_offset = o;
  endfunction

endpackage

// ==== tb/dcbf_asserts.sv ====
// Port-level assertions of the dual clock buffer
`timescale 1ns/10ps
module dcbf_asserts
  import dcbf_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic odd_parity_in,
  input wire logic left_port_clock_in,
  input wire logic left_select_n_in,
  input wire logic left_transfer_enable_in,
  input wire logic left_write_in,
  input wire logic left_mailbox_select_in,
  input wire logic left_parity_gen_in,
  input wire logic [DATA_W-1:0] left_data_bus_in,
  input wire logic left_data_bus_oe_out,
  input wire logic left_empty_n_out,
  input wire logic left_full_n_out,
  input wire logic left_almost_empty_n_out,
  input wire logic left_almost_full_n_out,
  input wire logic left_parity_error_n_out,
  input wire logic right_port_clock_in,
  input wire logic right_select_n_in,
  input wire logic right_transfer_enable_in,
  input wire logic right_write_in,
  input wire logic right_mailbox_select_in,
  input wire logic [DATA_W-1:0] right_data_bus_out,
  input wire logic right_empty_n_out,
  input wire logic right_full_n_out,
  input wire logic forward_mail_flag_n_out,
  input wire logic reverse_mail_flag_n_out
);
  logic lpc_r, rpc_r, ledge, redge, rgo, rmr, lmw, lfrc, lok;
  logic [NUM_BYTES-1:0] bok;
  // Previous port clock samples, high out of reset so no false edge
  always_ff @(posedge clk_in) begin
    lpc_r <= nrst_in ? left_port_clock_in : 1'b1;
    rpc_r <= nrst_in ? right_port_clock_in : 1'b1;
  end
  // Decoded port edges and accesses
  assign ledge = left_port_clock_in & ~lpc_r;
  assign redge = right_port_clock_in & ~rpc_r;
  assign rgo = redge & ~right_select_n_in & right_transfer_enable_in;
  assign rmr = rgo & ~right_write_in & right_mailbox_select_in;
  assign lmw = ledge & ~left_select_n_in & left_transfer_enable_in & left_write_in & left_mailbox_select_in;
  assign lfrc = ~left_write_in & left_mailbox_select_in & left_parity_gen_in;
  assign lok = &bok;
  // Per-byte parity of the left bus
  for (genvar i = 0; i < NUM_BYTES; i++) begin : g_par
    assign bok[i] = ((^left_data_bus_in[i*BYTE_W +: BYTE_W]) == odd_parity_in);
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_left_bus_drive: assert property (left_data_bus_oe_out == (!left_select_n_in && !left_write_in))
    else $error("left bus drive wrong");
  a_reset_flag_state: assert property ($rose(nrst_in) |-> !left_empty_n_out && !right_empty_n_out
    && !left_full_n_out && !right_full_n_out && !left_almost_empty_n_out && left_almost_full_n_out
    && forward_mail_flag_n_out && reverse_mail_flag_n_out)
    else $error("flags wrong after reset");
  a_fwd_mail_set: assert property ($fell(forward_mail_flag_n_out) |-> $past(lmw) || $past(lmw, 2))
    else $error("mail flag fell without a write");
  a_fwd_mail_clear: assert property ($rose(forward_mail_flag_n_out) |->
    $past(rmr) || $past(rmr, 2) || !$past(nrst_in))
    else $error("mail flag rose without a collect");
  a_right_empty_edge: assert property ($rose(right_empty_n_out) |-> $past(redge))
    else $error("right empty rose off a port edge");
  a_left_empty_edge: assert property ($rose(left_empty_n_out) |-> $past(ledge))
    else $error("left empty rose off a port edge");
  a_right_read_blocked: assert property (rgo && !right_write_in && !right_mailbox_select_in
    && !right_empty_n_out |=> $stable(right_data_bus_out) [*2])
    else $error("read of empty queue moved data");
  a_left_parity_check: assert property (!lfrc |=> lfrc || left_parity_error_n_out == $past(lok))
    else $error("left parity flag wrong");
  c_mail_collect: cover property (rmr);
  c_right_data: cover property ($rose(right_empty_n_out));
  c_left_full: cover property ($fell(left_full_n_out));
endmodule
bind dcbf_top dcbf_asserts chk_u (.clk_in, .nrst_in, .odd_parity_in, .left_port_clock_in, .left_select_n_in,
  .left_transfer_enable_in, .left_write_in, .left_mailbox_select_in, .left_parity_gen_in, .left_data_bus_in,
  .left_data_bus_oe_out, .left_empty_n_out, .left_full_n_out, .left_almost_empty_n_out, .left_almost_full_n_out,
  .left_parity_error_n_out, .right_port_clock_in, .right_select_n_in, .right_transfer_enable_in, .right_write_in,
  .right_mailbox_select_in, .right_data_bus_out, .right_empty_n_out, .right_full_n_out, .forward_mail_flag_n_out,
  .reverse_mail_flag_n_out);

// ==== tb/dcbf_port_model.sv ====
// Port-side master model: free-running port clock and one access task
`timescale 1ns/10ps
module dcbf_port_model
  import dcbf_pkg::*;
#(
  parameter int HALF = 2
) (
  input wire logic clk_in,
  input wire logic [DATA_W-1:0] bus_in,
  output logic port_clock_out,
  output logic sel_n_out,
  output logic en_out,
  output logic wr_out,
  output logic mb_out,
  output logic pg_out,
  output logic [DATA_W-1:0] drive_out
);
  int cnt = 0;
  logic [DATA_W-1:0] rd_data;
  // Idle and deselected
  initial begin
    port_clock_out = 1'b0;
    sel_n_out = 1'b1;
    en_out = 1'b0;
    wr_out = 1'b0;
    mb_out = 1'b0;
    pg_out = 1'b0;
    drive_out = '0;
    rd_data = '0;
  end
  always @(posedge clk_in) begin
    if (cnt == HALF - 1) begin
      cnt <= 0;
      port_clock_out <= #1 ~port_clock_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // controls held over one port rise
  task automatic acc(input logic w, input logic m, input logic g, input logic [DATA_W-1:0] d);
    while (port_clock_out) @(posedge clk_in);
    #1;
    sel_n_out = 1'b0;
    en_out = 1'b1;
    wr_out = w;
    mb_out = m;
    pg_out = g;
    if (w) drive_out = d;
    // taken where the port clock is first seen high
    do @(posedge clk_in); while (!port_clock_out);
    #1;
    en_out = 1'b0;
    // released lines carry the inverse word
    if (w) begin
      sel_n_out = 1'b1;
      drive_out = ~d;
    end
    repeat (2) @(posedge clk_in);
    rd_data = bus_in;
    #1;
    sel_n_out = 1'b1;
    wr_out = 1'b0;
    mb_out = 1'b0;
    pg_out = 1'b0;
  endtask
endmodule

// ==== tb/tb_dcbf_top.sv ====
// Self-checking bench of the dual clock bidirectional buffer
`timescale 1ns/10ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %h, expected %h", $time, got, exp); end end
module tb_dcbf_top
  import dcbf_pkg::*;
();
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [1:0] osel = 2'h0;
  logic odd = 1'b1;
  int fails = 0;
  int n_compared = 0;
  logic [DATA_W-1:0] lo, ro, lm, rm;
  logic loe, roe, lpc, lsn, len, lwr, lmb, lpg, rpc, rsn, ren, rwr, rmb, rpg;
  logic lef_n, lff_n, lae_n, laf_n, lpe_n, ref_n, rff_n, rae_n, raf_n, rpe_n, fwd_n, rev_n;
  // Bus level from both drivers
  wire [DATA_W-1:0] lbus = loe ? lo : lm;
  wire [DATA_W-1:0] rbus = roe ? ro : rm;
  always #(CLK_PERIOD_NS / 2.0) clk_in = ~clk_in;
  dcbf_top dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .offset_select_lo_in(osel[0]), .offset_select_hi_in(osel[1]),
    .odd_parity_in(odd), .left_port_clock_in(lpc), .left_select_n_in(lsn), .left_transfer_enable_in(len),
    .left_write_in(lwr), .left_mailbox_select_in(lmb), .left_parity_gen_in(lpg), .left_data_bus_in(lbus),
    .left_data_bus_out(lo), .left_data_bus_oe_out(loe), .left_empty_n_out(lef_n), .left_full_n_out(lff_n),
    .left_almost_empty_n_out(lae_n), .left_almost_full_n_out(laf_n), .left_parity_error_n_out(lpe_n),
    .right_port_clock_in(rpc), .right_select_n_in(rsn), .right_transfer_enable_in(ren), .right_write_in(rwr),
    .right_mailbox_select_in(rmb), .right_parity_gen_in(rpg), .right_data_bus_in(rbus), .right_data_bus_out(ro),
    .right_data_bus_oe_out(roe), .right_empty_n_out(ref_n), .right_full_n_out(rff_n),
    .right_almost_empty_n_out(rae_n), .right_almost_full_n_out(raf_n), .right_parity_error_n_out(rpe_n),
    .forward_mail_flag_n_out(fwd_n), .reverse_mail_flag_n_out(rev_n));
  dcbf_port_model #(.HALF(2)) lm_u (.clk_in(clk_in), .bus_in(lbus), .port_clock_out(lpc), .sel_n_out(lsn),
    .en_out(len), .wr_out(lwr), .mb_out(lmb), .pg_out(lpg), .drive_out(lm));
  dcbf_port_model #(.HALF(3)) rm_u (.clk_in(clk_in), .bus_in(rbus), .port_clock_out(rpc), .sel_n_out(rsn),
    .en_out(ren), .wr_out(rwr), .mb_out(rmb), .pg_out(rpg), .drive_out(rm));
  // Distinct word per index
  function automatic logic [DATA_W-1:0] word(input int i);
    word = 36'hA5A5A5A5A ^ DATA_W'(i);
  endfunction
  // Top bit of each byte set for the chosen parity sense
  function automatic logic [DATA_W-1:0] fixpar(input logic [DATA_W-1:0] w, input logic o);
    fixpar = w;
    for (int b = 0; b < 4; b++) fixpar[b*9+8] = (^w[b*9 +: 8]) ^ o;
  endfunction
  // Long enough for three edges of either port clock
  task automatic settle();
    repeat (24) @(posedge clk_in);
    #1;
  endtask
  task automatic do_reset(input logic [1:0] s);
    @(posedge clk_in);
    #1;
    nrst_in = 1'b0;
    osel = s;
    repeat (4) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
  endtask
  task automatic t_reset();
    do_reset(2'h0);
    `CHK({lef_n, ref_n, lff_n, rff_n, lae_n, rae_n, laf_n, raf_n, fwd_n, rev_n}, 10'h00F)
    settle();
    `CHK({lff_n, rff_n, lef_n, ref_n}, 4'hC)
    $display("reset test done");
  endtask
  // Fill to full and drain with offset preset s
  task automatic t_fill(input logic [1:0] s);
    int e;
    do_reset(s);
    e = 16 - 4 * int'(s);
    settle();
    for (int i = 1; i <= 65; i++) begin
      lm_u.acc(1'b1, 1'b0, 1'b0, word(i));
      if (i == e || i == e + 1 || i == 63 - e || i == 64 - e || i == 64) begin
        settle();
        `CHK(rae_n, logic'(i > e))
        `CHK(laf_n, logic'(64 - i > e))
        `CHK(lff_n, logic'(i < 64))
      end
    end
    for (int i = 1; i <= 64; i++) begin
      rm_u.acc(1'b0, 1'b0, 1'b0, '0);
      `CHK(rm_u.rd_data, word(i))
    end
    settle();
    `CHK(ref_n, 1'b0)
    rm_u.acc(1'b0, 1'b0, 1'b0, '0);
    `CHK(rm_u.rd_data, word(64))
    $display("fill test done");
  endtask
  task automatic t_mail();
    lm_u.acc(1'b1, 1'b1, 1'b0, 36'h123456789);
    `CHK(fwd_n, 1'b0)
    lm_u.acc(1'b1, 1'b1, 1'b0, 36'hFEDCBA987);
    rm_u.acc(1'b0, 1'b1, 1'b0, '0);
    `CHK(rm_u.rd_data, 36'h123456789)
    `CHK(fwd_n, 1'b1)
    rm_u.acc(1'b1, 1'b1, 1'b0, 36'h02468ACE1);
    `CHK(rev_n, 1'b0)
    lm_u.acc(1'b0, 1'b1, 1'b0, '0);
    `CHK(lm_u.rd_data, 36'h02468ACE1)
    `CHK(rev_n, 1'b1)
    $display("mail test done");
  endtask
  task automatic t_parity();
    logic [DATA_W-1:0] g;
    for (int o = 0; o < 2; o++) begin
      odd = o[0];
      g = fixpar(36'h0CAFE1234, o[0]);
      lm_u.acc(1'b1, 1'b0, 1'b0, g);
      `CHK(lpe_n, 1'b0)
      lm_u.acc(1'b1, 1'b0, 1'b0, g ^ 36'h804020100);
      `CHK(lpe_n, 1'b1)
      settle();
      rm_u.acc(1'b0, 1'b0, 1'b0, '0);
      `CHK(rm_u.rd_data, g)
      `CHK(rpe_n, 1'b1)
      rm_u.acc(1'b0, 1'b0, 1'b1, '0);
      `CHK(rm_u.rd_data, g)
    end
    $display("parity test done");
  endtask
  task automatic t_both();
    fork
      lm_u.acc(1'b1, 1'b0, 1'b0, 36'h111111111);
      rm_u.acc(1'b1, 1'b0, 1'b0, 36'h222222222);
    join
    `CHK(lef_n, 1'b0)
    settle();
    `CHK({lef_n, ref_n}, 2'h3)
    fork
      lm_u.acc(1'b0, 1'b0, 1'b0, '0);
      rm_u.acc(1'b0, 1'b0, 1'b0, '0);
    join
    `CHK({lm_u.rd_data, rm_u.rd_data}, {36'h222222222, 36'h111111111})
    $display("both ports test done");
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    for (int s = 0; s < 4; s++) t_fill(2'(s));
    t_mail();
    t_parity();
    t_both();
    tally_and_finish();
  end
  // Watchdog at about five times the expected run
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule

// ==== verilog/dcbf_skid.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module dcbf_skid
  import dcbf_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] slot_r [2];
  logic wr_idx_r;
  logic rd_idx_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready_out = (count_r != 2'h2);
  assign out_valid_out = (count_r != 2'h0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = slot_r[rd_idx_r];

  // Slot write
  always_ff @(posedge clk_in) begin
    if (push) begin
      slot_r[wr_idx_r] <= in_data_in;
    end
  end

  // Indices and occupancy
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      wr_idx_r <= 1'b0;
      rd_idx_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wr_idx_r <= ~wr_idx_r;
      end
      if (pop) begin
        rd_idx_r <= ~rd_idx_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule

// ==== verilog/dcbf_top.sv ====
// Dual clock bidirectional buffer: two queues, two mailboxes, flags and parity
//
// Behaviour
// R01 - Two 64x36 queues, one each direction
// R02 - Transfers only on qualified port clock rises
// R03 - Coincident write and read on one edge
// R04 - Full flags synchronized to writing port clock
// R05 - Empty flags synchronized to reading port clock
// R06 - Two 36-bit mailboxes bypass the queues
// R07 - Mail flag marks uncollected mailbox word
// R08 - Passive parity check on each port
// R09 - Optional per-port parity generation on reads
// R10 - Left almost-empty low at low fill
// R11 - Right almost-empty low at low fill
// R12 - Left almost-full low at little space
// R13 - Right almost-full low at little space
// R14 - 36-bit two-way data bus per port
// R15 - Transfers and flags update on clock rise
// R16 - Select low needed; else bus undriven
// R17 - Left empty low blocks left reads
// R18 - Left empty rises second edge after data
// R19 - Right empty low blocks right reads
// R20 - Right empty rises second edge after data
// R21 - Enable high also needed for transfers
// R22 - Full blocks writes, rises second edge
// R23 - Offset selects latched at reset release
// R24 - Mailbox write lowers flag, read raises
// R25 - Gray pointers cross between port domains
// R26 - Direction input picks write or read
`timescale 1ns/10ps
module dcbf_top
  import dcbf_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic offset_select_lo_in,
  input wire logic offset_select_hi_in,
  input wire logic odd_parity_in,
  input wire logic left_port_clock_in,
  input wire logic left_select_n_in,
  input wire logic left_transfer_enable_in,
  input wire logic left_write_in,
  input wire logic left_mailbox_select_in,
  input wire logic left_parity_gen_in,
  input wire logic [DATA_W-1:0] left_data_bus_in,
  output logic [DATA_W-1:0] left_data_bus_out,
  output logic left_data_bus_oe_out,
  output logic left_empty_n_out,
  output logic left_full_n_out,
  output logic left_almost_empty_n_out,
  output logic left_almost_full_n_out,
  output logic left_parity_error_n_out,
  input wire logic right_port_clock_in,
  input wire logic right_select_n_in,
  input wire logic right_transfer_enable_in,
  input wire logic right_write_in,
  input wire logic right_mailbox_select_in,
  input wire logic right_parity_gen_in,
  input wire logic [DATA_W-1:0] right_data_bus_in,
  output logic [DATA_W-1:0] right_data_bus_out,
  output logic right_data_bus_oe_out,
  output logic right_empty_n_out,
  output logic right_full_n_out,
  output logic right_almost_empty_n_out,
  output logic right_almost_full_n_out,
  output logic right_parity_error_n_out,
  output logic forward_mail_flag_n_out,
  output logic reverse_mail_flag_n_out
);

  // ----------------------------------------------------------------
  // Port signals gathered by index: 0 left, 1 right
  // ----------------------------------------------------------------
  logic [1:0] pclk;
  logic [1:0] sel_n;
  logic [1:0] en;
  logic [1:0] wr;
  logic [1:0] mb;
  logic [1:0] pg;
  logic [DATA_W-1:0] din [2];
  logic [1:0] pclk_prev_r;
  logic [1:0] pedge;
  logic [1:0] acc;
  logic [1:0] awake0_r;
  logic [1:0] awake1_r;
  logic [PTR_W-1:0] offset_r;
  logic nrst_d_r;
  // Per queue: 0 left to right queue, 1 right to left queue
  logic [1:0] q_full_n;
  logic [1:0] q_empty_n;
  logic [1:0] q_ae_n;
  logic [1:0] q_af_n;
  logic [1:0] q_push;
  logic [1:0] q_take;
  logic [DATA_W-1:0] q_head [2];
  // Per mailbox: index is the writing port
  logic [DATA_W-1:0] mail_r [2];
  logic [1:0] mail_flag_n_r;
  logic [DATA_W-1:0] dout_r [2];
  logic [1:0] perr_n_r;

  assign pclk = {right_port_clock_in, left_port_clock_in};
  assign sel_n = {right_select_n_in, left_select_n_in};
  assign en = {right_transfer_enable_in, left_transfer_enable_in};
  assign wr = {right_write_in, left_write_in};
  assign mb = {right_mailbox_select_in, left_mailbox_select_in};
  assign pg = {right_parity_gen_in, left_parity_gen_in};
  assign din[0] = left_data_bus_in;
  assign din[1] = right_data_bus_in;

  // ----------------------------------------------------------------
  // Port clock edges and access qualification
  // ----------------------------------------------------------------
  // Previous port clock level for rise detection
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pclk_prev_r <= 2'h3;
    end else begin
      pclk_prev_r <= pclk;
    end
  end

  // R15 rising edge pulse
  assign pedge = pclk & ~pclk_prev_r;
  // R02 R21 select low and enable high
  assign acc = pedge & ~sel_n & en;

  // Wake-up shift, full flags stay low for two edges after reset
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      awake0_r <= AWAKE_RST;
      awake1_r <= AWAKE_RST;
    end else begin
      awake0_r <= awake0_r | pedge;
      awake1_r <= awake1_r | (pedge & awake0_r);
    end
  end

  // R23 latch offset select at reset release
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      nrst_d_r <= 1'b0;
      offset_r <= OFFSET_RST;
    end else begin
      nrst_d_r <= 1'b1;
      if (!nrst_d_r) begin
        offset_r <= dcbf_offset({offset_select_hi_in, offset_select_lo_in});
      end
    end
  end

  // ----------------------------------------------------------------
  // Queues, one per direction
  // ----------------------------------------------------------------
  for (genvar d = 0; d < 2; d++) begin : g_queue
    localparam int W = d;
    localparam int R = 1 - d;
    // R01 queue storage
    logic [DATA_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wptr_r;
    logic [PTR_W-1:0] wgray_r;
    logic [PTR_W-1:0] rptr_r;
    logic [PTR_W-1:0] rgray_r;
    logic [PTR_W-1:0] rsync1_r;
    logic [PTR_W-1:0] rsync2_r;
    logic [PTR_W-1:0] wsync1_r;
    logic [PTR_W-1:0] wsync2_r;
    logic [PTR_W-1:0] used_w;
    logic [PTR_W-1:0] free_w;
    logic [PTR_W-1:0] used_r;
    logic arr_full;
    logic buf_ready;
    logic buf_valid;
    logic [DATA_W-1:0] buf_data;
    logic drain;
    logic [PTR_W-1:0] wptr_nxt;
    logic [PTR_W-1:0] rptr_nxt;

    // Two-entry buffer between the writing port and the array
    dcbf_skid #(
      .WIDTH(DATA_W)
    ) u_skid (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(q_push[d]),
      .in_ready_out(buf_ready),
      .in_data_in(din[W]),
      .out_valid_out(buf_valid),
      .out_ready_in(~arr_full),
      .out_data_out(buf_data)
    );

    // Writer side occupancy from synced read pointer
    assign used_w = wptr_r - dcbf_gray2bin(rsync2_r);
    assign free_w = DEPTH_CNT - used_w;
    assign arr_full = (used_w == DEPTH_CNT);
    assign drain = buf_valid & ~arr_full;
    assign wptr_nxt = wptr_r + 7'h01;
    // R22 full blocks writes, low until second edge
    assign q_full_n[d] = awake1_r[W] & ~arr_full & buf_ready;
    // R03 write path independent of read path
    assign q_push[d] = acc[W] & wr[W] & ~mb[W] & q_full_n[d];
    // R12 R13 almost full on free space
    assign q_af_n[d] = (free_w > offset_r);

    // Reader side occupancy from synced write pointer
    assign used_r = dcbf_gray2bin(wsync2_r) - rptr_r;
    // R05 R18 R20 empty from reader domain registers
    assign q_empty_n[d] = (wsync2_r != rgray_r);
    // R10 R11 almost empty on fill level
    assign q_ae_n[d] = (used_r > offset_r);
    // R17 R19 reads blocked while empty
    assign q_take[d] = acc[R] & ~wr[R] & ~mb[R] & q_empty_n[d];
    assign q_head[d] = mem[rptr_r[ADDR_W-1:0]];
    assign rptr_nxt = rptr_r + 7'h01;

    // Array write
    always_ff @(posedge clk_in) begin
      if (drain) begin
        mem[wptr_r[ADDR_W-1:0]] <= buf_data;
      end
    end

    // R25 write pointer in binary and gray
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        wptr_r <= PTR_RST;
        wgray_r <= PTR_RST;
      end else if (drain) begin
        wptr_r <= wptr_nxt;
        wgray_r <= dcbf_bin2gray(wptr_nxt);
      end
    end

    // R25 read pointer in binary and gray
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        rptr_r <= PTR_RST;
        rgray_r <= PTR_RST;
      end else if (q_take[d]) begin
        rptr_r <= rptr_nxt;
        rgray_r <= dcbf_bin2gray(rptr_nxt);
      end
    end

    // R04 read pointer into writer domain, two stages
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        rsync1_r <= PTR_RST;
        rsync2_r <= PTR_RST;
      end else if (pedge[W]) begin
        rsync1_r <= rgray_r;
        rsync2_r <= rsync1_r;
      end
    end

    // R05 write pointer into reader domain, two stages
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        wsync1_r <= PTR_RST;
        wsync2_r <= PTR_RST;
      end else if (pedge[R]) begin
        wsync1_r <= wgray_r;
        wsync2_r <= wsync1_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mailboxes, output registers and parity per port
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int O = 1 - p;
    logic mail_wr;
    logic mail_rd;

    // R06 mailbox write when flag shows it collected
    assign mail_wr = acc[p] & wr[p] & mb[p] & mail_flag_n_r[p];
    // R26 direction low reads the other mailbox
    assign mail_rd = acc[O] & ~wr[O] & mb[O];

    // Mailbox data
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        mail_r[p] <= DATA_RST;
      end else if (mail_wr) begin
        mail_r[p] <= din[p];
      end
    end

    // R07 R24 new mail flag, write wins over collect
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        mail_flag_n_r[p] <= 1'b1;
      end else if (mail_wr) begin
        mail_flag_n_r[p] <= 1'b0;
      end else if (mail_rd) begin
        mail_flag_n_r[p] <= 1'b1;
      end
    end

    // R09 output register with optional parity generation
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        dout_r[p] <= DATA_RST;
      end else if (q_take[O]) begin
        dout_r[p] <= pg[p] ? dcbf_parity_gen(q_head[O], odd_parity_in) : q_head[O];
      end else if (acc[p] && !wr[p] && mb[p]) begin
        dout_r[p] <= pg[p] ? dcbf_parity_gen(mail_r[O], odd_parity_in) : mail_r[O];
      end
    end

    // R08 passive check, forced high on generating mailbox read
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        perr_n_r[p] <= 1'b1;
      end else if (!wr[p] && mb[p] && pg[p]) begin
        perr_n_r[p] <= 1'b1;
      end else begin
        perr_n_r[p] <= dcbf_parity_ok(din[p], odd_parity_in);
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // R14 R16 drive bus only when selected and reading
  assign left_data_bus_out = dout_r[0];
  assign left_data_bus_oe_out = ~left_select_n_in & ~left_write_in;
  assign right_data_bus_out = dout_r[1];
  assign right_data_bus_oe_out = ~right_select_n_in & ~right_write_in;

  // Port flags from their own port's registers, except the mail flags, set by one port and cleared by the other
  assign left_empty_n_out = q_empty_n[1];
  assign left_almost_empty_n_out = q_ae_n[1];
  assign left_full_n_out = q_full_n[0];
  assign left_almost_full_n_out = q_af_n[0];
  assign right_empty_n_out = q_empty_n[0];
  assign right_almost_empty_n_out = q_ae_n[0];
  assign right_full_n_out = q_full_n[1];
  assign right_almost_full_n_out = q_af_n[1];
  assign left_parity_error_n_out = perr_n_r[0];
  assign right_parity_error_n_out = perr_n_r[1];
  assign forward_mail_flag_n_out = mail_flag_n_r[0];
  assign reverse_mail_flag_n_out = mail_flag_n_r[1];

endmodule
